// [hdl/sarseq_map.svh]
// Offsets, field positions, reset values and timing counts of the converter sequencer.
// Assumes an 8-bit CPU data bus whose low address byte selects the register.
// Overview of operation
// - Convert selected channel back to back while run is set
// - One completion interrupt per conversion
// - Sample at start, hold through conversion
// - Decide bits MSB first from comparator
// - After LSB, copy approximation into results
// - Result word: upper ten bits, low six zero
// - High byte gets upper eight result bits
// - Result reads insert one bus wait cycle
// - Pin function picks analog or digital port
// - Channel select feeds chosen pin to sampler
// - Reset clears mode register to zero
// - Both bits clear stops; enable only waits
// - Run converts; powers comparator itself if needed
// - Mode register writes insert one wait cycle
// - Speed field divides clock; 22 conversion clocks
// - Channel field three low bits, rest zero
`ifndef SARSEQ_MAP_SVH
`define SARSEQ_MAP_SVH

`define SARSEQ_OFS_RES_LO   8'h08
`define SARSEQ_OFS_RES_HI   8'h09
`define SARSEQ_OFS_MODE     8'h28
`define SARSEQ_OFS_CHAN     8'h29
`define SARSEQ_OFS_PINF     8'h30

`define SARSEQ_MODE_RUN     7
`define SARSEQ_MODE_FR_HI   5
`define SARSEQ_MODE_FR_LO   3
`define SARSEQ_MODE_LV_HI   2
`define SARSEQ_MODE_LV_LO   1
`define SARSEQ_MODE_CMPEN   0

`define SARSEQ_MODE_RST     8'h00
`define SARSEQ_CHAN_RST     3'h0
`define SARSEQ_PINF_RST     8'h00
`define SARSEQ_RES_RST      10'h000

`define SARSEQ_RES_BITS     10
`define SARSEQ_CONV_CLKS    22
`define SARSEQ_SMP_CLKS     (`SARSEQ_CONV_CLKS - `SARSEQ_RES_BITS)

`endif

// [hdl/sarseq_pkg.sv]
// Types shared by the converter sequencer files.
// Assumes nothing of its surroundings.
`default_nettype none
package sarseq_pkg;
  typedef enum logic [1:0] {SQ_IDLE, SQ_SAMPLE, SQ_CONVERT} sarseq_state_t;
  typedef enum logic [1:0] {BS_IDLE, BS_WAIT, BS_DONE} sarseq_bus_t;
endpackage : sarseq_pkg
`default_nettype wire

// [hdl/sarseq_prescale.sv]
// Conversion clock prescaler: one tick every div_in peripheral clocks.
// Assumes div_in holds steady while run_in is high.
`default_nettype none
module sarseq_prescale #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Control
  input  wire logic         run_in,
  input  wire logic [W-1:0] div_in,
  // Tick
  output logic              tick
);
  if (W < 1)
  begin : g_chk
    $error("W must be at least 1");
  end
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  always_comb
  begin
    nxt_cnt = '0;
    tick    = 1'b0;
    if (run_in)
    begin
      if (cnt_ff >= div_in - W'(1))
        tick = 1'b1;
      else
        nxt_cnt = cnt_ff + W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule : sarseq_prescale
`default_nettype wire

// [hdl/sarseq_top.sv]
// Successive-approximation converter sequencer with its CPU-side registers.
// Assumes a single-cycle CPU strobe per access, a comparator whose output
// is high when the held sample is at or above the trial code, and an
// 8-bit port with a 16-bit read path for the result word.
`include "sarseq_map.svh"
`default_nettype none
module sarseq_top
  import sarseq_pkg::*;
#(
  parameter int NCH = 8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // CPU register port
  input  wire logic [7:0]  cpu_addr,
  input  wire logic        cpu_rd,
  input  wire logic        cpu_wr,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [15:0] cpu_rdata,
  output logic             cpu_ack,
  output logic             cpu_wait,
  // Analog front end
  input  wire logic        comp_in,
  output logic      [2:0]  channel_sel,
  output logic             sample_en,
  output logic      [9:0]  trial_code,
  output logic             comp_power,
  output logic      [7:0]  pin_analog,
  // Completion
  output logic             conversion_done_irq
);
  if (NCH < 1 || NCH > 8)
  begin : g_chk
    $error("NCH must lie between 1 and 8");
  end
  logic [7:0]  converter_mode_ff, nxt_mode;
  logic [2:0]  channel_select_ff, nxt_chan;
  logic [7:0]  pin_function_ff, nxt_pinf;
  logic [9:0]  result_ff, nxt_result;
  logic [7:0]  result_high_ff, nxt_result_high;
  sarseq_bus_t bus_ff, nxt_bus;
  logic [7:0]  pend_addr_ff, nxt_pend_addr;
  logic [7:0]  pend_data_ff, nxt_pend_data;
  logic        pend_wr_ff, nxt_pend_wr;
  logic [15:0] rdata_ff, nxt_rdata;
  logic        ack_ff, nxt_ack;
  logic        wait_ff, nxt_wait;
  sarseq_state_t state_ff, nxt_state;
  logic [4:0]  smp_cnt_ff, nxt_smp_cnt;
  logic [3:0]  bit_idx_ff, nxt_bit_idx;
  logic [9:0]  approximation_ff, nxt_approx;
  logic        irq_ff, nxt_irq;
  logic        sample_ff, nxt_sample;
  logic        power_ff, nxt_power;
  logic        run, tick, waited;
  logic [3:0]  div;
  assign run = converter_mode_ff[`SARSEQ_MODE_RUN];

  always_comb
  begin
    case (converter_mode_ff[`SARSEQ_MODE_FR_HI:`SARSEQ_MODE_FR_LO])
      3'h1:    div = 4'h8;
      3'h2:    div = 4'h6;
      3'h3:    div = 4'h4;
      3'h4:    div = 4'h3;
      3'h5:    div = 4'h2;
      default: div = 4'hc;
    endcase
  end

  sarseq_prescale #(
    .W(4)
  ) u_prescale (
    .clk    (clk),
    .nrst   (nrst),
    .run_in (run),
    .div_in (div),
    .tick   (tick)
  );
  function automatic logic [15:0] read_reg(input logic [7:0] a, input logic [9:0] res,
    input logic [7:0] hi, input logic [7:0] mode, input logic [2:0] ch, input logic [7:0] pf);
    case (a)
      `SARSEQ_OFS_RES_LO: read_reg = {res, 6'h00};
      `SARSEQ_OFS_RES_HI: read_reg = {8'h00, hi};
      `SARSEQ_OFS_MODE:   read_reg = {8'h00, mode};
      `SARSEQ_OFS_CHAN:   read_reg = {13'h0, ch};
      `SARSEQ_OFS_PINF:   read_reg = {8'h00, pf};
      default:            read_reg = 16'h0000;
    endcase
  endfunction : read_reg
  // Result reads and mode writes take an extra cycle before they answer.
  assign waited = (cpu_rd && (cpu_addr == `SARSEQ_OFS_RES_LO || cpu_addr == `SARSEQ_OFS_RES_HI))
               || (cpu_wr && cpu_addr == `SARSEQ_OFS_MODE);
  // Register port.
  always_comb
  begin
    nxt_bus       = BS_IDLE;
    nxt_pend_addr = pend_addr_ff;
    nxt_pend_data = pend_data_ff;
    nxt_pend_wr   = pend_wr_ff;
    nxt_rdata     = rdata_ff;
    nxt_ack       = 1'b0;
    nxt_wait      = 1'b0;
    nxt_mode      = converter_mode_ff;
    nxt_chan      = channel_select_ff;
    nxt_pinf      = pin_function_ff;
    case (bus_ff)
      BS_WAIT:
      begin
        nxt_ack = 1'b1;
        if (pend_wr_ff)
          nxt_mode = pend_data_ff;
        else
          nxt_rdata = read_reg(pend_addr_ff, result_ff, result_high_ff,
                               converter_mode_ff, channel_select_ff, pin_function_ff);
      end
      default:
      begin
        if ((cpu_rd || cpu_wr) && waited)
        begin
          nxt_bus       = BS_WAIT;
          nxt_wait      = 1'b1;
          nxt_pend_addr = cpu_addr;
          nxt_pend_data = cpu_wdata;
          nxt_pend_wr   = cpu_wr;
        end
        else if (cpu_wr)
        begin
          nxt_ack = 1'b1;
          if (cpu_addr == `SARSEQ_OFS_CHAN)
            nxt_chan = cpu_wdata[2:0];
          if (cpu_addr == `SARSEQ_OFS_PINF)
            nxt_pinf = cpu_wdata;
        end
        else if (cpu_rd)
        begin
          nxt_ack   = 1'b1;
          nxt_rdata = read_reg(cpu_addr, result_ff, result_high_ff, converter_mode_ff,
                               channel_select_ff, pin_function_ff);
        end
      end
    endcase
  end
  // Conversion sequencer.
  always_comb
  begin
    nxt_state       = state_ff;
    nxt_smp_cnt     = smp_cnt_ff;
    nxt_bit_idx     = bit_idx_ff;
    nxt_approx      = approximation_ff;
    nxt_result      = result_ff;
    nxt_result_high = result_high_ff;
    nxt_irq         = 1'b0;
    nxt_sample      = 1'b0;
    nxt_power       = run || converter_mode_ff[`SARSEQ_MODE_CMPEN];
    case (state_ff)
      SQ_IDLE:
      begin
        nxt_approx = '0;
        if (run)
        begin
          nxt_state   = SQ_SAMPLE;
          nxt_smp_cnt = '0;
          nxt_sample  = 1'b1;
        end
      end
      SQ_SAMPLE:
      begin
        nxt_sample = 1'b1;
        if (tick)
        begin
          if (smp_cnt_ff == 5'(`SARSEQ_SMP_CLKS - 1))
          begin
            nxt_state   = SQ_CONVERT;
            nxt_sample  = 1'b0;
            nxt_bit_idx = 4'(`SARSEQ_RES_BITS - 1);
            nxt_approx  = 10'h200;
          end
          else
            nxt_smp_cnt = smp_cnt_ff + 5'h01;
        end
      end
      SQ_CONVERT:
      begin
        if (tick)
        begin
          nxt_approx[bit_idx_ff] = comp_in;
          if (bit_idx_ff == 4'h0)
          begin
            nxt_result      = nxt_approx;
            nxt_result_high = nxt_approx[9:2];
            nxt_irq         = 1'b1;
            nxt_state       = SQ_SAMPLE;
            nxt_smp_cnt     = '0;
            nxt_sample      = 1'b1;
          end
          else
          begin
            nxt_bit_idx             = bit_idx_ff - 4'h1;
            nxt_approx[nxt_bit_idx] = 1'b1;
          end
        end
      end
      default:
        nxt_state = SQ_IDLE;
    endcase
    if (!run)
    begin
      nxt_state  = SQ_IDLE;
      nxt_sample = 1'b0;
      nxt_irq    = 1'b0;
      nxt_result      = result_ff;
      nxt_result_high = result_high_ff;
    end
  end

  always_ff @(posedge clk)
  begin
    pend_addr_ff      <= nxt_pend_addr;
    pend_data_ff      <= nxt_pend_data;
    pend_wr_ff        <= nxt_pend_wr;
    smp_cnt_ff        <= nxt_smp_cnt;
    bit_idx_ff        <= nxt_bit_idx;
    if (!nrst)
    begin
      converter_mode_ff <= `SARSEQ_MODE_RST;
      channel_select_ff <= `SARSEQ_CHAN_RST;
      pin_function_ff   <= `SARSEQ_PINF_RST;
      result_ff         <= `SARSEQ_RES_RST;
      result_high_ff    <= 8'h00;
      bus_ff            <= BS_IDLE;
      rdata_ff          <= 16'h0000;
      ack_ff            <= 1'b0;
      wait_ff           <= 1'b0;
      state_ff          <= SQ_IDLE;
      approximation_ff  <= 10'h000;
      irq_ff            <= 1'b0;
      sample_ff         <= 1'b0;
      power_ff          <= 1'b0;
    end
    else
    begin
      converter_mode_ff <= nxt_mode;
      channel_select_ff <= nxt_chan;
      pin_function_ff   <= nxt_pinf;
      result_ff         <= nxt_result;
      result_high_ff    <= nxt_result_high;
      bus_ff            <= nxt_bus;
      rdata_ff          <= nxt_rdata;
      ack_ff            <= nxt_ack;
      wait_ff           <= nxt_wait;
      state_ff          <= nxt_state;
      approximation_ff  <= nxt_approx;
      irq_ff            <= nxt_irq;
      sample_ff         <= nxt_sample;
      power_ff          <= nxt_power;
    end
  end
  assign cpu_rdata           = rdata_ff;
  assign cpu_ack             = ack_ff;
  assign cpu_wait            = wait_ff;
  assign channel_sel         = channel_select_ff;
  assign sample_en           = sample_ff;
  assign trial_code          = approximation_ff;
  assign comp_power          = power_ff;
  assign pin_analog          = pin_function_ff;
  assign conversion_done_irq = irq_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_RESTART: assert property (irq_ff |-> state_ff == SQ_SAMPLE && sample_ff)
    else $error("conversion did not restart after completion");
  AST_IRQ_ONCE: assert property (irq_ff |=> !irq_ff)
    else $error("completion interrupt longer than one cycle");
  AST_HOLD: assert property (state_ff == SQ_CONVERT |-> !sample_ff)
    else $error("sampler not holding during conversion");
  AST_MSB_FIRST: assert property ((state_ff == SQ_SAMPLE ##1 state_ff == SQ_CONVERT)
                                  |-> bit_idx_ff == 4'h9 && approximation_ff == 10'h200)
    else $error("approximation did not start at the top bit");
  AST_RES_PAIR: assert property (irq_ff |-> result_high_ff == result_ff[9:2])
    else $error("high byte does not match result word");
  AST_RES_STEADY: assert property (!irq_ff |-> $stable(result_ff) || $past(!nrst))
    else $error("result changed without completion interrupt");
  AST_WAIT: assert property ((cpu_rd && cpu_addr == `SARSEQ_OFS_RES_LO && bus_ff == BS_IDLE)
                             |=> cpu_wait && !cpu_ack ##1 cpu_ack && cpu_rdata[5:0] == 6'h00)
    else $error("result word read did not wait or low bits not zero");
  AST_MODE_WAIT: assert property ((cpu_wr && cpu_addr == `SARSEQ_OFS_MODE && bus_ff == BS_IDLE)
                                  |=> cpu_wait ##1 cpu_ack && converter_mode_ff == $past(cpu_wdata, 2))
    else $error("mode write did not wait one cycle");
  AST_STOP: assert property (!run |=> state_ff == SQ_IDLE && !sample_en)
    else $error("converter kept running with run bit clear");
  AST_POWER: assert property (run |=> comp_power)
    else $error("comparator not powered during conversion");
  AST_RESET: assert property ($rose(nrst) |-> converter_mode_ff == 8'h00)
    else $error("mode register not cleared by reset");
endmodule : sarseq_top
`default_nettype wire

// [verification/sarseq_afe_model.sv]
// Sample-and-hold and comparator model that faces the converter sequencer.
// Assumes the bench drives one input code for each channel on vin.
`default_nettype none
module sarseq_afe_model (
  // Clock
  input  wire logic            clk,
  // Front end
  input  wire logic [2:0]      channel_sel,
  input  wire logic            sample_en,
  input  wire logic [9:0]      trial_code,
  input  wire logic            comp_power,
  input  wire logic [7:0]      pin_analog,
  input  wire logic [7:0][9:0] vin,
  // Decision
  output logic                 comp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held_ff;
  logic       tgl_ff = 1'b0;
  always @(posedge clk)
  begin
    tgl_ff <= ~tgl_ff;
    if (sample_en)
      held_ff <= pin_analog[channel_sel] ? vin[channel_sel] : 10'h000;
  end
  // An unpowered comparator gives no usable decision, so it toggles.
  assign comp_in = comp_power ? (held_ff >= trial_code) : tgl_ff;
endmodule : sarseq_afe_model
`default_nettype wire

// [verification/sar_adc_sequencer_tb_top.sv]
// Self-checking bench for the converter sequencer and its register port.
// Assumes the front-end model answers the comparator input.
`include "sarseq_map.svh"
`default_nettype none
module sar_adc_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk;
  logic            nrst;
  logic [7:0]      cpu_addr;
  logic            cpu_rd;
  logic            cpu_wr;
  logic [7:0]      cpu_wdata;
  logic [15:0]     cpu_rdata;
  logic            cpu_ack;
  logic            cpu_wait;
  logic            comp_in;
  logic [2:0]      channel_sel;
  logic            sample_en;
  logic [9:0]      trial_code;
  logic            comp_power;
  logic [7:0]      pin_analog;
  logic            conversion_done_irq;
  logic [7:0][9:0] vin;
  logic [15:0]     rd;
  logic [2:0]      ch;
  int              failures;
  int              n_checks;
  int              cyc = 0;
  int              t0;
  int              t1;
  logic [9:0]      vals [6] = '{10'h3ff, 10'h000, 10'h200, 10'h1ff, 10'h2a5, 10'h15a};
  int              dv   [6] = '{12, 8, 6, 4, 3, 2};

  sarseq_top u_dut (
    .clk, .nrst, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata, .cpu_ack,
    .cpu_wait, .comp_in, .channel_sel, .sample_en, .trial_code, .comp_power,
    .pin_analog, .conversion_done_irq
  );
  sarseq_afe_model u_afe (
    .clk, .channel_sel, .sample_en, .trial_code, .comp_power, .pin_analog, .vin,
    .comp_in
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One strobe cycle, then a bounded wait for the acknowledge.
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        input int lat_exp);
    int lat;
    lat = 0;
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_rd    <= ~w;
    cpu_wr    <= w;
    @(posedge clk);
    cpu_rd <= 1'b0;
    cpu_wr <= 1'b0;
    do
    begin
      @(posedge clk);
      lat++;
    end
    while (cpu_ack !== 1'b1 && lat < 8);
    rd = cpu_rdata;
    check(16'(lat), 16'(lat_exp));
  endtask : access

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    access(1'b1, a, d, (a == `SARSEQ_OFS_MODE) ? 2 : 1);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    access(1'b0, a, 8'h00, (a == `SARSEQ_OFS_RES_LO || a == `SARSEQ_OFS_RES_HI) ? 2 : 1);
    check(rd, exp);
  endtask : reg_rd

  task automatic wait_irq(input int lim, output int at);
    at = -1;
    repeat (lim)
    begin
      @(posedge clk);
      if (conversion_done_irq === 1'b1)
      begin
        at = cyc;
        break;
      end
    end
    @(posedge clk);
    check(16'(conversion_done_irq), 16'h0000);
  endtask : wait_irq

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end

  initial
  begin
    nrst = 1'b0;
    cpu_addr = 8'h00;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_wdata = 8'h00;
    vin = '0;
    failures = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check(16'({sample_en, comp_power, conversion_done_irq}), 16'h0000);
    reg_rd(`SARSEQ_OFS_MODE, 16'h0000);
    reg_rd(`SARSEQ_OFS_CHAN, 16'h0000);
    reg_rd(`SARSEQ_OFS_PINF, 16'h0000);
    reg_rd(`SARSEQ_OFS_RES_LO, 16'h0000);
    reg_rd(`SARSEQ_OFS_RES_HI, 16'h0000);
    reg_rd(8'h55, 16'h0000);
    reg_wr(`SARSEQ_OFS_RES_LO, 8'hff);
    reg_rd(`SARSEQ_OFS_RES_LO, 16'h0000);
    reg_wr(`SARSEQ_OFS_CHAN, 8'hfd);
    reg_rd(`SARSEQ_OFS_CHAN, 16'h0005);
    check(16'(channel_sel), 16'h0005);
    reg_wr(`SARSEQ_OFS_PINF, 8'hff);
    @(posedge clk);
    check(16'(pin_analog), 16'h00ff);
    reg_wr(`SARSEQ_OFS_MODE, 8'h01);
    wait_irq(300, t0);
    check(16'(t0 + 1), 16'h0000);
    check(16'({comp_power, sample_en}), 16'h0002);
    for (int k = 0; k < 6; k++)
    begin
      ch = 3'(k + 2);
      reg_wr(`SARSEQ_OFS_CHAN, {5'h00, ch});
      vin[ch] <= vals[k];
      reg_wr(`SARSEQ_OFS_MODE, 8'h01);
      repeat (250) @(posedge clk);
      reg_wr(`SARSEQ_OFS_MODE, {1'b1, 1'b0, 3'(k), 2'h0, 1'b1});
      // Move the input while the held sample is being converted.
      repeat (12 * dv[k] + 6) @(posedge clk);
      vin[ch] <= ~vals[k];
      wait_irq(700, t0);
      reg_rd(`SARSEQ_OFS_RES_LO, {vals[k], 6'h00});
      reg_rd(`SARSEQ_OFS_RES_HI, {8'h00, vals[k][9:2]});
      check(16'(channel_sel), 16'(ch));
      wait_irq(700, t1);
      check(16'(t1 - t0), 16'(22 * dv[k]));
      reg_rd(`SARSEQ_OFS_RES_LO, {~vals[k], 6'h00});
      // Stop first and keep the speed field; it changes only while stopped.
      reg_wr(`SARSEQ_OFS_MODE, {2'h0, 3'(k), 2'h0, 1'b1});
    end
    reg_wr(`SARSEQ_OFS_MODE, 8'h01);
    reg_wr(`SARSEQ_OFS_MODE, 8'h81);
    repeat (60) @(posedge clk);
    reg_wr(`SARSEQ_OFS_MODE, 8'h00);
    wait_irq(400, t0);
    check(16'(t0 + 1), 16'h0000);
    check(16'({comp_power, sample_en}), 16'h0000);
    reg_rd(`SARSEQ_OFS_RES_LO, {~vals[5], 6'h00});
    reg_wr(`SARSEQ_OFS_MODE, 8'h80);
    repeat (2) @(posedge clk);
    check(16'(comp_power), 16'h0001);
    wait_irq(400, t0);
    check(16'(t0 > 0), 16'h0001);
    // Reset again while converting, with a non-zero mode register.
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check(16'({sample_en, comp_power, conversion_done_irq}), 16'h0000);
    reg_rd(`SARSEQ_OFS_MODE, 16'h0000);
    reg_wr(`SARSEQ_OFS_MODE, 8'h00);
    end_sim();
  end
endmodule : sar_adc_sequencer_tb_top
`default_nettype wire
